// [rtl/aphc_pkg.sv]
/*
 Shared constants for the converter host control link.
 Assumes a single 50 MHz clock shared by both ends.
*/
`default_nettype none
package aphc_pkg;
   localparam int DATA_W = 12;
   localparam int CHAN_W = 2;
   localparam int CONV_CLKS = 16;
   localparam logic [4:0] CONV_LAST = 5'(CONV_CLKS - 1);
   localparam logic [CHAN_W-1:0] CHAN_0 = 2'h0;
   localparam logic [CHAN_W-1:0] CHAN_1 = 2'h1;
   localparam logic [CHAN_W-1:0] CHAN_2 = 2'h2;
   localparam logic [CHAN_W-1:0] CHAN_3 = 2'h3;
   localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
   localparam logic [3:0] CHAN_RST = 4'h1;
   // Host timing: last count of each strobe, which stays low three cycles
   localparam logic [1:0] STROBE_CLKS = 2'h2;
endpackage
`default_nettype wire

// [rtl/aphc_if.sv]
/*
 Parallel bus between converter device and host controller.
 Assumes the bench resolves the data bus wire from the drive enable.
*/
`default_nettype none
interface aphc_if;
   logic chip_select_n;
   logic convert_strobe_n;
   logic read_strobe_n;
   logic channel_sel_lo;
   logic channel_sel_hi;
   logic busy_n;
   logic [aphc_pkg::DATA_W-1:0] data_out;
   logic data_oe;
   modport device (
      input chip_select_n, convert_strobe_n, read_strobe_n, channel_sel_lo, channel_sel_hi,
      output busy_n, data_out, data_oe
   );
   modport host (
      output chip_select_n, convert_strobe_n, read_strobe_n, channel_sel_lo, channel_sel_hi,
      input busy_n, data_out, data_oe
   );
endinterface
`default_nettype wire

// [rtl/aphc_device.sv]
/*
 Converter device end: start, address latch, busy and result port.
 Assumes strobes synchronous to ref_clk; samples come from user side.
*/
// Function
// RULE1 - Low select plus low convert starts conversion
// RULE2 - Start puts result outputs high impedance
// RULE3 - Start selects input from address bits
// RULE4 - Select and read low drive result
// RULE5 - Busy low throughout the conversion
// RULE6 - Completion raises busy, enables result outputs
// RULE7 - Sixteen clocks per sample
// RULE8 - Address latched on rising read/convert edge
// RULE9 - Code maps high bit first to input
// RULE10 - Lowest data output carries result LSB
// RULE11 - Host waits for busy high first
// RULE12 - Outputs driven only during active read
`default_nettype none
module aphc_device (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link
   aphc_if.device lnk,
   // Analog sample values, one per input
   input wire logic [aphc_pkg::DATA_W-1:0] analog_input_0,
   input wire logic [aphc_pkg::DATA_W-1:0] analog_input_1,
   input wire logic [aphc_pkg::DATA_W-1:0] analog_input_2,
   input wire logic [aphc_pkg::DATA_W-1:0] analog_input_3,
   // Status to user side
   output logic [3:0] chan_onehot,
   output logic conv_done
);
   typedef enum logic {aphc_idle, aphc_conv} aphc_state_t;

   // One-hot view of a channel code, high address bit first
   function automatic logic [3:0] aphc_decode(input logic [aphc_pkg::CHAN_W-1:0] code);
      aphc_decode = 4'h1 << code; // RULE9
   endfunction

   // Strobe history
   logic cnv_d, next_cnv_d;
   logic rd_d, next_rd_d;

   // Conversion sequencer
   aphc_state_t state, next_state;
   logic [4:0] cnt, next_cnt;
   logic busy_n, next_busy_n;
   logic done, next_done;

   // Channel latch, one bit per analog input
   logic [3:0] onehot, next_onehot;

   // Result port
   logic [aphc_pkg::DATA_W-1:0] result, next_result;
   logic [aphc_pkg::DATA_W-1:0] dout, next_dout;
   logic oe, next_oe;

   // Link events and sample selection
   logic [aphc_pkg::CHAN_W-1:0] pin_code;
   logic start, cnv_rise, rd_rise, reading, finish;
   logic [aphc_pkg::DATA_W-1:0] sample [4];
   logic [aphc_pkg::DATA_W-1:0] masked [4];
   logic [aphc_pkg::DATA_W-1:0] picked;

   ////////////////////////////////////////////////////////////////////////
   assign pin_code = {lnk.channel_sel_hi, lnk.channel_sel_lo};
   // Start only from idle; starts during a conversion are refused
   assign start = (state == aphc_idle) && !lnk.chip_select_n && !lnk.convert_strobe_n && cnv_d; // RULE1
   assign cnv_rise = lnk.convert_strobe_n && !cnv_d;
   assign rd_rise = lnk.read_strobe_n && !rd_d;
   assign reading = !lnk.chip_select_n && !lnk.read_strobe_n;
   assign finish = (state == aphc_conv) && (cnt == aphc_pkg::CONV_LAST); // RULE7

   ////////////////////////////////////////////////////////////////////////
   // Sample of each input, indexed by channel code
   assign sample[aphc_pkg::CHAN_0] = analog_input_0;
   assign sample[aphc_pkg::CHAN_1] = analog_input_1;
   assign sample[aphc_pkg::CHAN_2] = analog_input_2;
   assign sample[aphc_pkg::CHAN_3] = analog_input_3;

   // Only the latched channel passes; the others read zero
   for (genvar g = 0; g < $bits(onehot); g++) begin : g_pick
      assign masked[g] = onehot[g] ? sample[g] : '0;
   end

   assign picked = masked[0] | masked[1] | masked[2] | masked[3];

   ////////////////////////////////////////////////////////////////////////
   // Strobe history, reset to idle level so no false edge follows reset
   always_comb begin
      next_cnv_d = lnk.convert_strobe_n;
      next_rd_d = lnk.read_strobe_n;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnv_d <= 1'b1;
         rd_d <= 1'b1;
      end else begin
         cnv_d <= next_cnv_d;
         rd_d <= next_rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion sequencer: busy low for sixteen cycles
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_busy_n = busy_n;
      next_done = 1'b0;

      case (state)
         aphc_idle: begin
            if (start) begin
               next_state = aphc_conv;
               next_cnt = '0;
               next_busy_n = 1'b0; // RULE5
            end
         end
         aphc_conv: begin
            // Completion: busy high, one-cycle done pulse
            if (finish) begin
               next_state = aphc_idle;
               next_busy_n = 1'b1; // RULE6
               next_done = 1'b1;
            end else begin
               next_cnt = 5'(cnt + 5'h01); // RULE7
            end
         end
         default: begin
            next_state = aphc_idle;
            next_busy_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= aphc_idle;
         cnt <= '0;
         busy_n <= 1'b1;
         done <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         busy_n <= next_busy_n;
         done <= next_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel latch: taken at start, again on trailing strobe edges
   always_comb begin
      next_onehot = onehot;
      // Address pins pick the channel at the start edge
      if (start) begin
         next_onehot = aphc_decode(pin_code); // RULE3
      end else if (cnv_rise || rd_rise) begin
         next_onehot = aphc_decode(pin_code); // RULE8
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         onehot <= aphc_pkg::CHAN_RST;
      end else begin
         onehot <= next_onehot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result port
   always_comb begin
      next_result = result;
      if (finish) begin
         // Result taken from the channel latched for this conversion
         next_result = picked;
      end
      // Result port drives only while reading and not converting
      next_oe = reading && next_busy_n && !start; // RULE2 RULE6 RULE12
      next_dout = next_result; // RULE4 RULE10
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         result <= aphc_pkg::DATA_RST;
         dout <= aphc_pkg::DATA_RST;
         oe <= 1'b0;
      end else begin
         result <= next_result;
         dout <= next_dout;
         oe <= next_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link and status outputs straight from registers
   assign lnk.busy_n = busy_n;
   assign lnk.data_oe = oe;
   assign lnk.data_out = dout;
   assign chan_onehot = onehot;
   assign conv_done = done;
endmodule
`default_nettype wire

// [rtl/aphc_host.sv]
/*
 Host controller end: issues conversions and reads results.
 Assumes the user pulses requests only while ready is high.
*/
`default_nettype none
module aphc_host (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link
   aphc_if.host lnk,
   // User requests
   input wire logic conv_req,
   input wire logic [1:0] conv_chan,
   input wire logic read_req,
   // User answers
   output logic ready,
   output logic [aphc_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid
);
   typedef enum logic [1:0] {aphh_idle, aphh_conv, aphh_read, aphh_wait} aphc_hstate_t;

   aphc_hstate_t state, next_state;
   logic [1:0] cnt, next_cnt;
   logic cs_n, next_cs_n, wr_n, next_wr_n, rd_n, next_rd_n;
   logic [1:0] addr, next_addr;
   logic rdy, next_rdy, vld, next_vld;
   logic [aphc_pkg::DATA_W-1:0] data, next_data;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cs_n = cs_n;
      next_wr_n = wr_n;
      next_rd_n = rd_n;
      next_addr = addr;
      next_rdy = rdy;
      next_vld = 1'b0;
      next_data = data;
      case (state)
         aphh_idle: begin
            // Only act once the device reports not busy
            if (lnk.busy_n && conv_req) begin // RULE11
               next_state = aphh_conv;
               next_cs_n = 1'b0;
               next_wr_n = 1'b0; // RULE1
               next_addr = conv_chan; // RULE3
               next_cnt = '0;
               next_rdy = 1'b0;
            end else if (lnk.busy_n && read_req) begin // RULE11
               next_state = aphh_read;
               next_cs_n = 1'b0;
               next_rd_n = 1'b0; // RULE4
               next_cnt = '0;
               next_rdy = 1'b0;
            end
         end
         aphh_conv: begin
            next_cnt = 2'(cnt + 2'h1);
            if (cnt == aphc_pkg::STROBE_CLKS) begin
               next_wr_n = 1'b1; // RULE8
               next_cs_n = 1'b1;
               next_state = aphh_wait;
            end
         end
         aphh_read: begin
            next_cnt = 2'(cnt + 2'h1);
            if (cnt == aphc_pkg::STROBE_CLKS) begin
               next_data = lnk.data_out;
               next_vld = 1'b1;
               next_rd_n = 1'b1;
               next_cs_n = 1'b1;
               next_state = aphh_wait;
            end
         end
         aphh_wait: begin
            // Hold off until busy is seen high; an earlier low is not checked
            if (lnk.busy_n) begin // RULE5 RULE7
               next_state = aphh_idle;
               next_rdy = 1'b1;
            end
         end
         default: next_state = aphh_idle;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= aphh_idle;
         cnt <= '0;
         cs_n <= 1'b1;
         wr_n <= 1'b1;
         rd_n <= 1'b1;
         addr <= aphc_pkg::CHAN_0;
         rdy <= 1'b1;
         vld <= 1'b0;
         data <= aphc_pkg::DATA_RST;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cs_n <= next_cs_n;
         wr_n <= next_wr_n;
         rd_n <= next_rd_n;
         addr <= next_addr;
         rdy <= next_rdy;
         vld <= next_vld;
         data <= next_data;
      end
   end

   assign lnk.chip_select_n = cs_n;
   assign lnk.convert_strobe_n = wr_n;
   assign lnk.read_strobe_n = rd_n;
   assign lnk.channel_sel_lo = addr[0];
   assign lnk.channel_sel_hi = addr[1];
   assign ready = rdy;
   assign rd_data = data;
   assign rd_valid = vld;
endmodule
`default_nettype wire

// [test/aphc_props.sv]
/*
 Checker for the device-to-host link signals.
 Assumes tb instantiates it beside the link interface.
*/
`default_nettype none
module aphc_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link
   input wire logic chip_select_n,
   input wire logic convert_strobe_n,
   input wire logic read_strobe_n,
   input wire logic channel_sel_lo,
   input wire logic channel_sel_hi,
   input wire logic busy_n,
   input wire logic [aphc_pkg::DATA_W-1:0] data_out,
   input wire logic data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] lo_cnt;
   logic [4:0] next_lo_cnt;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // Busy low cycles
   always_comb begin
      next_lo_cnt = busy_n ? 5'h00 : lo_cnt + 5'h01;
   end
   always_ff @(posedge ref_clk) begin
      lo_cnt <= srst ? 5'h00 : next_lo_cnt;
   end
   ////////////////////////////////////////////////////////////////
   sequence s_start;
      !chip_select_n && $fell(convert_strobe_n) && busy_n;
   endsequence
   sequence s_busy_hold;
      !busy_n [*8];
   endsequence
   sequence s_strobe_pulse;
      !convert_strobe_n [*3] ##1 convert_strobe_n;
   endsequence
   chk_start_busy_low: assert property (s_start |=> s_busy_hold)
      else $error("busy not held low after start");
   chk_start_tristate: assert property (s_start |=> !data_oe)
      else $error("outputs driven after start");
   chk_busy_cause: assert property ($fell(busy_n) |-> $past(!chip_select_n && !convert_strobe_n))
      else $error("busy fell without start");
   chk_conv_length: assert property ($rose(busy_n) |-> lo_cnt == 5'(aphc_pkg::CONV_CLKS))
      else $error("conversion length wrong");
   chk_read_drive: assert property (!chip_select_n && !read_strobe_n && busy_n |=> data_oe)
      else $error("read not answered");
   chk_oe_release: assert property (data_oe && (chip_select_n || read_strobe_n) |=> !data_oe)
      else $error("outputs driven outside read");
   chk_busy_no_drive: assert property (!busy_n |-> !data_oe)
      else $error("outputs driven while busy");
   chk_read_stable: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
      else $error("result changed during read");
   chk_host_pulse: assert property ($fell(convert_strobe_n) |-> s_strobe_pulse)
      else $error("convert strobe width wrong");
   chk_host_waits: assert property ($fell(convert_strobe_n) || $fell(read_strobe_n) |-> busy_n)
      else $error("access while busy");
   chk_addr_hold: assert property ($rose(convert_strobe_n) |-> $stable({channel_sel_hi, channel_sel_lo}))
      else $error("address moved at strobe edge");
endmodule
`default_nettype wire

// [test/tb.sv]
/*
 Bench joining device and host ends over the link.
 Assumes the design files and package are compiled first.
*/
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic conv_req = 1'b0;
   logic read_req = 1'b0;
   logic [1:0] conv_chan = 2'h0;
   logic [11:0] smp [4] = '{12'h001, 12'h802, 12'h4a5, 12'hf3c};
   logic [3:0] chan_onehot;
   logic conv_done, ready, rd_valid;
   logic [11:0] rd_data;
   int n_errors = 0;
   int cmp_count = 0;
   aphc_if lnk ();
   aphc_device u_aphc_device (.ref_clk(ref_clk), .srst(srst), .lnk(lnk), .analog_input_0(smp[0]),
      .analog_input_1(smp[1]), .analog_input_2(smp[2]), .analog_input_3(smp[3]),
      .chan_onehot(chan_onehot), .conv_done(conv_done));
   aphc_host u_aphc_host (.ref_clk(ref_clk), .srst(srst), .lnk(lnk), .conv_req(conv_req),
      .conv_chan(conv_chan), .read_req(read_req), .ready(ready), .rd_data(rd_data), .rd_valid(rd_valid));
   aphc_props u_aphc_props (.ref_clk(ref_clk), .srst(srst), .chip_select_n(lnk.chip_select_n),
      .convert_strobe_n(lnk.convert_strobe_n), .read_strobe_n(lnk.read_strobe_n),
      .channel_sel_lo(lnk.channel_sel_lo), .channel_sel_hi(lnk.channel_sel_hi),
      .busy_n(lnk.busy_n), .data_out(lnk.data_out), .data_oe(lnk.data_oe));
   always #10 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic conv(input logic [1:0] ch);
      logic d;
      d = 1'b0;
      while (ready !== 1'b1) @(negedge ref_clk);
      conv_chan = ch;
      conv_req = 1'b1;
      @(negedge ref_clk);
      conv_req = 1'b0;
      repeat (40) begin
         @(negedge ref_clk);
         if (conv_done === 1'b1) d = 1'b1;
         if (d && ready === 1'b1) break;
      end
      chk("conv_done", 12'h001, 12'(d));
      chk("chan_onehot", 12'(4'h1 << ch), 12'(chan_onehot));
   endtask
   task automatic rd(input logic [11:0] exp);
      logic v;
      v = 1'b0;
      while (ready !== 1'b1) @(negedge ref_clk);
      read_req = 1'b1;
      @(negedge ref_clk);
      read_req = 1'b0;
      repeat (20) begin
         @(negedge ref_clk);
         if (rd_valid === 1'b1) begin
            v = 1'b1;
            break;
         end
      end
      chk("rd_valid", 12'h001, 12'(v));
      chk("rd_data", exp, rd_data);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(negedge ref_clk);
      srst = 1'b0;
      chk("data_oe", 12'h000, 12'(lnk.data_oe));
      for (int c = 0; c < 4; c++) begin
         conv(2'(c));
         rd(smp[c]);
      end
      conv(2'h3);
      conv(2'h1);
      rd(smp[1]);
      rd(smp[1]);
      conv(2'h2);
      smp[2] = 12'h3c5;
      rd(12'h4a5);
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      $display("FAIL watchdog exp finish got timeout");
      end_sim();
   end
endmodule
`default_nettype wire
